// *** verif/cmsd_ctl_model.sv ***
`timescale 1ns/10ps
// controller model: turns a channel and mode request into line levels
module cmsd_ctl_model (
    // request from the bench
    input wire logic [4:0] req_chan,
    input wire logic [1:0] req_mode,
    input wire logic fmt_auto,
    input wire logic fast_fmt,
    // select lines towards the block
    output logic [3:0] data_in,
    output logic [1:0] mode_in,
    output logic [2:0] freq_in
);
    logic [3:0] chan_idx; // zero-based channel, bit 3 marks the upper bank
    logic [1:0] mode_pick; // mode actually driven
    assign chan_idx = 4'(req_chan - 5'h01);
    // format detect: mode b for the fast format, mode a for all others
    assign mode_pick = fmt_auto ? {1'b0, fast_fmt} : req_mode;
    // the two upper data lines carry the mode, the low ones vary with channel
    assign data_in = {mode_pick, chan_idx[1:0]};
    // upper bank is asked for by pulling the second mode line low
    assign mode_in = {~chan_idx[3], chan_idx[0]};
    assign freq_in = chan_idx[2:0];
endmodule

// *** verif/cmsd_top_chk.sv ***
`timescale 1ns/10ps
module cmsd_top_chk #(
    parameter int RELOCK_COUNT = 4
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // controller lines
    input wire logic [3:0] data_in,
    input wire logic [1:0] mode_in,
    input wire logic [2:0] freq_in,
    // exciter lines
    input wire logic [4:1] data_out,
    input wire logic mode_sel_line1,
    input wire logic mode_sel_line2,
    input wire logic chan_out_line1,
    input wire logic chan_out_line2,
    input wire logic chan_out_line3,
    // decoded selection
    input wire logic [3:0] active_channel,
    input wire logic [1:0] active_mode,
    input wire logic tx_key
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------
    // pass-through lines, checked once inputs sat still past the pipe
    // ------------------------------------------------------------
    property p_data_map;
        $stable(data_in)[*8] |-> data_out == data_in;
    endproperty
    a_data_map: assert property (p_data_map) else $error("data lines wrong");
    property p_mode_map;
        $stable(mode_in)[*8] |-> {mode_sel_line2, mode_sel_line1} == mode_in;
    endproperty
    a_mode_map: assert property (p_mode_map) else $error("mode lines wrong");
    property p_chan_map;
        $stable(freq_in)[*8] |-> {chan_out_line3, chan_out_line2, chan_out_line1} == freq_in;
    endproperty
    a_chan_map: assert property (p_chan_map) else $error("channel lines wrong");
    // ------------------------------------------------------------
    // decoding and keying
    // ------------------------------------------------------------
    property p_chan_idx;
        ($stable(mode_in) && $stable(freq_in))[*8] |-> active_channel == {~mode_in[1], freq_in};
    endproperty
    a_chan_idx: assert property (p_chan_idx) else $error("channel index wrong");
    property p_mode_pick;
        $stable(data_in)[*8] |-> active_mode == data_in[3:2] || active_mode == 2'h3;
    endproperty
    a_mode_pick: assert property (p_mode_pick) else $error("mode wrong");
    property p_unkey;
        $changed(active_channel) |-> !tx_key;
    endproperty
    a_unkey: assert property (p_unkey) else $error("key held on change");
    // bench runs a relock of four cycles, so four low cycles is the floor
    property p_relock;
        $changed(active_channel) |-> !tx_key[*4];
    endproperty
    a_relock: assert property (p_relock) else $error("relock too short");
    // run length of a low key since the last channel change
    logic [15:0] low_run;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_run <= 16'h0;
        end else if ($changed(active_channel)) begin
            low_run <= 16'h1;
        end else if (!tx_key && low_run != 16'h0) begin
            low_run <= low_run + 16'h1;
        end else begin
            low_run <= 16'h0;
        end
    end
    // the key may only come back after the full relock count
    property p_relock_len;
        $rose(tx_key) && low_run != 16'h0 |-> low_run >= 16'(RELOCK_COUNT + 1);
    endproperty
    a_relock_len: assert property (p_relock_len) else $error("relock count short");
    property p_mode_keeps_key;
        $changed(active_mode) && $stable(active_channel) && $past(tx_key) |-> tx_key;
    endproperty
    a_mode_keeps_key: assert property (p_mode_keeps_key) else $error("mode unkeyed");
endmodule

// *** verif/tb_channel_mode_select_decoder.sv ***
`timescale 1ns/10ps
module tb_channel_mode_select_decoder import cmsd_pkg::*;;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] req_chan = 5'h01; // requested channel 1..16
    logic [1:0] req_mode = 2'h0;
    logic fmt_auto = 1'b0;
    logic fast_fmt = 1'b0;
    logic [3:0] data_in, active_channel;
    logic [1:0] mode_in, active_mode, bresp, rresp, resp;
    logic [2:0] freq_in;
    logic [4:1] data_out;
    logic mode_sel_line1, mode_sel_line2, chan_out_line1, chan_out_line2, chan_out_line3;
    logic tx_key, awready, wready, bvalid, arready, rvalid;
    logic [15:0] active_dev, active_ofs;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    int bad_count = 0, tests_run = 0, cycles = 0;
    cmsd_ctl_model ctl (.req_chan, .req_mode, .fmt_auto, .fast_fmt, .data_in, .mode_in, .freq_in);
    // short relock keeps the sweep brief
    cmsd_top #(.RELOCK_COUNT(4)) dut (.aclk, .aresetn, .data_in, .mode_in, .freq_in, .data_out,
        .mode_sel_line1, .mode_sel_line2, .chan_out_line1, .chan_out_line2, .chan_out_line3,
        .active_channel, .active_mode, .active_dev, .active_ofs, .tx_key,
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    always #2.5 aclk = ~aclk;
    // ------------------------------------------------------------
    // watchdog: far above the sweep length
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // write: address and data offered together, each dropped once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    // request a channel and mode, then wait out pipe plus relock
    task automatic sel(input logic [4:0] c, input logic [1:0] m);
        @(posedge aclk);
        req_chan <= c;
        req_mode <= m;
        repeat (14) @(posedge aclk);
    endtask
    task automatic final_report;
        $display("mismatches %0d, checks %0d", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin : main
        int idx;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        axr(ADDR_CTRL);
        chk(rd, 32'(CTRL_RESET));
        axr(ADDR_TABLE_BASE);
        chk(rd, TABLE_RESET);
        axw(8'hc0, 32'h1);
        chk(resp, BRESP_SLVERR);
        axr(8'hc0);
        chk(rd, 32'h0);
        chk(resp, BRESP_SLVERR);
        // each slot and mode gets its own deviation and offset
        for (int i = 0; i < 32; i++) begin
            axw(ADDR_TABLE_BASE + 8'(i * 4), {8'h01, 8'(i), 8'h10, 8'(i)});
        end
        axr(ADDR_TABLE_BASE + 8'h7c);
        chk(rd, 32'h011f_101f);
        axw(ADDR_CTRL, 32'h1);
        for (int c = 1; c <= 16; c++) begin
            for (int m = 0; m < 4; m++) begin
                sel(5'(c), 2'(m));
                idx = ((c - 1) % 8) * 4 + m;
                chk(active_channel, 32'(c - 1));
                chk(active_mode, 32'(m));
                chk({active_ofs, active_dev}, {8'h01, 8'(idx), 8'h10, 8'(idx)});
                chk(data_out, {2'(m), 2'(c - 1)});
                chk({mode_sel_line2, mode_sel_line1}, {1'(c <= 8), 1'(c - 1)});
                chk({chan_out_line3, chan_out_line2, chan_out_line1}, 32'((c - 1) % 8));
                chk(tx_key, 32'h1);
            end
        end
        // alternative board forces mode d whatever the lines say
        axw(ADDR_CTRL, 32'h3);
        sel(5'h03, 2'h0);
        chk(active_mode, 32'h3);
        chk({active_ofs, active_dev}, 32'h010b_100b);
        axr(ADDR_STATUS);
        chk(rd, 32'h0000_0723);
        axr(ADDR_SEL_OUT);
        chk(rd, 32'h0000_00a2);
        axw(ADDR_CTRL, 32'h1);
        fmt_auto <= 1'b1;
        fast_fmt <= 1'b1;
        sel(5'h09, 2'h3);
        chk(active_mode, 32'h1);
        fast_fmt <= 1'b0;
        sel(5'h09, 2'h3);
        chk(active_mode, 32'h0);
        // deviation lanes only: the offset half of the word must survive
        wstrb <= 4'h3;
        axw(ADDR_TABLE_BASE, 32'hffff_5a5a);
        chk(resp, BRESP_OKAY);
        wstrb <= 4'hf;
        axr(ADDR_TABLE_BASE);
        chk(rd, 32'h0100_5a5a);
        final_report();
    end
endmodule
bind cmsd_top cmsd_top_chk #(.RELOCK_COUNT(RELOCK_COUNT)) chk (.aclk, .aresetn, .data_in,
    .mode_in, .freq_in, .data_out, .mode_sel_line1, .mode_sel_line2, .chan_out_line1,
    .chan_out_line2, .chan_out_line3, .active_channel, .active_mode, .tx_key);

// *** verilog/cmsd_pkg.sv ***
package cmsd_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_SEL_OUT = 8'h08;
    localparam logic [7:0] ADDR_TABLE_BASE = 8'h40;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_KEY_BIT = 0;
    localparam int CTRL_ALT_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int DEV_WIDTH = 16;
    localparam int OFS_WIDTH = 16;
    localparam logic [31:0] TABLE_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // geometry and timing
    // ------------------------------------------------------------
    localparam int STORED_CHANNELS = 8;
    localparam int MODE_COUNT = 4;
    localparam int CLK_MHZ = 200;
    localparam int RELOCK_US = 10;
    localparam int RELOCK_CYCLES = RELOCK_US * CLK_MHZ;

    // ------------------------------------------------------------
    // modulation modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CMSD_MODE_A,
        CMSD_MODE_B,
        CMSD_MODE_C,
        CMSD_MODE_D
    } cmsd_mode_e;

    localparam logic [1:0] BRESP_OKAY = 2'h0;
    localparam logic [1:0] BRESP_SLVERR = 2'h2;

endpackage

// *** verilog/cmsd_sync.sv ***
`timescale 1ns/10ps
// three-stage synchroniser: a bit changes once stages two and three agree
module cmsd_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] s1; // metastability stage, read only by s2
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    wire [WIDTH-1:0] agree = ~(s2 ^ s3);
    wire [WIDTH-1:0] next_dout = (agree & s3) | (~agree & dout);

    // shift chain, filtered output keeps old value while stages disagree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            dout <= '0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            dout <= next_dout;
        end
    end

endmodule

// *** verilog/cmsd_top.sv ***
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
// Overview of operation
// - each channel keeps four modes, deviation plus offset
// - data lines two and three choose mode
// - mode change keeps channel and key unchanged
// - channel change while keyed drops key first
// - eight stored channels; upper bank reuses lower
// - second mode line low selects upper bank
// - data inputs 0..3 drive data outputs 1..4
// - mode inputs 0,1 drive mode-select outputs 1,2
// - frequency inputs 0..2 drive channel-select outputs 1..3
// - alternative board offers only mode D
module cmsd_top
    import cmsd_pkg::*;
#(
    parameter int RELOCK_COUNT = RELOCK_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // controller select lines
    input wire logic [3:0] data_in,
    input wire logic [1:0] mode_in,
    input wire logic [2:0] freq_in,
    // exciter-side select lines
    output logic [4:1] data_out,
    output logic mode_sel_line1,
    output logic mode_sel_line2,
    output logic chan_out_line1,
    output logic chan_out_line2,
    output logic chan_out_line3,
    // decoded selection
    output logic [3:0] active_channel,
    output logic [1:0] active_mode,
    output logic [DEV_WIDTH-1:0] active_dev,
    output logic [OFS_WIDTH-1:0] active_ofs,
    output logic tx_key,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // table word index: channel slot times four plus mode
    function automatic logic [4:0] tbl_index(input logic [2:0] slot, input logic [1:0] mode);
        tbl_index = {slot, mode};
    endfunction

    // address falls inside the mode table window
    function automatic logic in_table(input logic [7:0] addr);
        in_table = (addr >= ADDR_TABLE_BASE) &&
            (addr < ADDR_TABLE_BASE + 8'(STORED_CHANNELS * MODE_COUNT * 4));
    endfunction

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    // all nine lines share one chain; pins that skew may still split over two cycles
    logic [8:0] sel_sync; // {freq, mode, data} after filtering

    cmsd_sync #(.WIDTH(9)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din({freq_in, mode_in, data_in}),
        .dout(sel_sync)
    );

    wire [3:0] data_s = sel_sync[3:0];
    wire [1:0] mode_s = sel_sync[5:4];
    wire [2:0] freq_s = sel_sync[8:6];

    // ------------------------------------------------------------
    // selection decode
    // ------------------------------------------------------------
    logic [1:0] ctrl; // key request, alternative board
    logic [31:0] mode_tbl [STORED_CHANNELS*MODE_COUNT];

    wire alt_board = ctrl[CTRL_ALT_BIT];
    wire key_req = ctrl[CTRL_KEY_BIT];
    // bank line low means upper bank
    // the synchroniser resets to zero, so the upper bank shows briefly after reset
    // and one relock period follows before the key can come up
    wire upper_bank = ~mode_s[1];
    wire [3:0] next_channel = {upper_bank, freq_s};
    // data lines two and three pick the mode; alt board forces D
    wire [1:0] req_mode = data_s[3:2];
    wire [1:0] next_mode = alt_board ? 2'(CMSD_MODE_D) : req_mode;
    // low three bits give the stored slot, so 9..16 mirror 1..8
    wire [2:0] slot = next_channel[2:0];
    wire [31:0] tbl_word = mode_tbl[tbl_index(slot, next_mode)];
    wire chan_change = (next_channel != active_channel);

    // ------------------------------------------------------------
    // pass-through select lines
    // ------------------------------------------------------------

    // each output follows exactly one synchronised input
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_out <= 4'h0;
            mode_sel_line1 <= 1'b0;
            mode_sel_line2 <= 1'b0;
            chan_out_line1 <= 1'b0;
            chan_out_line2 <= 1'b0;
            chan_out_line3 <= 1'b0;
        end else begin
            data_out <= data_s;
            mode_sel_line1 <= mode_s[0];
            mode_sel_line2 <= mode_s[1];
            chan_out_line1 <= freq_s[0];
            chan_out_line2 <= freq_s[1];
            chan_out_line3 <= freq_s[2];
        end
    end

    // ------------------------------------------------------------
    // channel, mode and key sequencing
    // ------------------------------------------------------------
    // the timer only counts cycles; there is no lock detect, so the count must cover
    // the slowest synthesizer settling time at this clock rate
    localparam int RW = $clog2(RELOCK_COUNT + 1);
    logic [RW-1:0] relock; // cycles left before the synthesizer may key
    wire relocking = (relock != '0);

    // a new channel reloads the relock timer; a new mode does not touch it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_channel <= 4'h0;
            relock <= '0;
        end else if (chan_change) begin
            active_channel <= next_channel;
            relock <= RW'(RELOCK_COUNT);
        end else if (relocking) begin
            relock <= relock - 1'b1;
        end
    end

    // mode and its settings follow every cycle without unkeying
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_mode <= 2'h0;
            active_dev <= '0;
            active_ofs <= '0;
        end else begin
            active_mode <= next_mode;
            active_dev <= tbl_word[DEV_WIDTH-1:0];
            active_ofs <= tbl_word[31:DEV_WIDTH];
        end
    end

    // key drops the same edge a channel change is seen
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_key <= 1'b0;
        end else begin
            tx_key <= key_req && !chan_change && !relocking;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire wr_ctrl = (aw_addr == ADDR_CTRL);
    wire wr_tbl = in_table(aw_addr);
    // status and select words take a write without effect, so only holes answer
    // with an error and software can probe the map safely
    wire wr_ok = wr_ctrl || wr_tbl || (aw_addr == ADDR_STATUS) || (aw_addr == ADDR_SEL_OUT);
    wire [4:0] wr_idx = 5'((aw_addr - ADDR_TABLE_BASE) >> 2);

    // capture address and data in either order, answer after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= BRESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_addr <= s_axi_awaddr;
                aw_held <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_held <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? BRESP_OKAY : BRESP_SLVERR;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // control register, low byte lane only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CTRL_RESET;
        end else if (do_write && wr_ctrl && w_strb[0]) begin
            ctrl <= w_data[1:0];
        end
    end

    // mode table: deviation low half, offset high half, byte lanes honoured
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < STORED_CHANNELS * MODE_COUNT; i++) begin
                mode_tbl[i] <= TABLE_RESET;
            end
        end else if (do_write && wr_tbl) begin
            for (int b = 0; b < 4; b++) begin
                if (w_strb[b]) begin
                    mode_tbl[wr_idx][b*8 +: 8] <= w_data[b*8 +: 8];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------
    wire [4:0] rd_idx = 5'((s_axi_araddr - ADDR_TABLE_BASE) >> 2);
    // status: bit 0 key request, bit 1 alternative board, bits 3:2 requested mode,
    // bits 7:4 channel, bits 9:8 active mode, bit 10 key, bit 11 relocking;
    // the requested mode shows the lines before any forcing to mode d
    wire [31:0] status_word = {20'h0, relocking, tx_key, active_mode, active_channel,
                               data_s[3:2], alt_board, key_req};
    wire [31:0] selout_word = {23'h0, chan_out_line3, chan_out_line2, chan_out_line1,
                               mode_sel_line2, mode_sel_line1, data_out};
    wire rd_ctrl = (s_axi_araddr == ADDR_CTRL);
    wire rd_stat = (s_axi_araddr == ADDR_STATUS);
    wire rd_sel = (s_axi_araddr == ADDR_SEL_OUT);
    wire rd_tbl = in_table(s_axi_araddr);
    wire [31:0] rd_word = rd_ctrl ? {30'h0, ctrl} :
                          rd_stat ? status_word :
                          rd_sel ? selout_word :
                          rd_tbl ? mode_tbl[rd_idx] : 32'h0;
    wire rd_ok = rd_ctrl || rd_stat || rd_sel || rd_tbl;

    // read data is taken in the cycle the address is accepted, so a status read
    // may lag the select lines by one cycle
    // one read at a time; arready drops while the answer stands
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= BRESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? BRESP_OKAY : BRESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule
